// *** verilog/pwm_irq_cull.sv ***
// Interrupt culling and buffered reload of the seven transfer registers.
// Assumes the counter core supplies its value and direction each clock,
// and moves by one step per clock so crest and valley last one cycle.
//
// Behaviour
// - Only crest and valley interrupts are culled.
// - Crest interrupt issued only while crest enable is set.
// - Valley interrupt issued only while valley enable is set.
// - Cull count masks that many enabled timings; zero means no culling.
// - Transfer culling set: transfer only where culled interrupt is issued.
// - Transfer culling clear: transfer at first timing after phase-one write.
// - Anytime select 1 updates buffers on write; 0 only on transfer.
// - Both enables give alternating crest and valley interrupts, culled.
// - Cycle, three duties, culling option, two converter compares are buffered.
// - Anytime mode ignores transfer culling; registers update independently.
// - Batch mode: anytime 0, any cull count, transfer culling 0.
// - Batch: phase-one write arms copy of all seven registers.
// - Batch transfer timings are every crest and every valley at 0001H.
// - Intermittent batch: anytime 0 and transfer culling 1.
// - Intermittent batch transfers only at the issued culled interrupt.
// - Duty match fires once per slope; later matches are ignored.
// - Cycle match is equality only; a passed value is missed.
// - Cycle match is ignored while counting down.
// - Anytime: duty rewritten before its match is compared directly.
// - Writing the culling option register clears the culling counter.
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_irq_cull
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [pwm_cull_pkg::AW-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [pwm_cull_pkg::DW-1:0] cnt_val,
   input wire logic count_down,
   output logic crest_irq,
   output logic valley_irq,
   output logic cycle_match,
   output logic [pwm_cull_pkg::NPH-1:0] duty_match,
   output logic [pwm_cull_pkg::DW-1:0] cycle_buf,
   output logic [pwm_cull_pkg::DW-1:0] duty1_buf,
   output logic [pwm_cull_pkg::DW-1:0] duty2_buf,
   output logic [pwm_cull_pkg::DW-1:0] duty3_buf,
   output logic [pwm_cull_pkg::DW-1:0] conv_a_buf,
   output logic [pwm_cull_pkg::DW-1:0] conv_b_buf
);
   import pwm_cull_pkg::*;

   logic ack_q;
   logic wr_acc;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic sh_hit;
   logic [2:0] wr_idx;
   logic [DW-1:0] wmerge;
   logic [DW-1:0] reg_q [NREG];
   logic [DW-1:0] buf_q [NREG];
   logic anytime_q;
   logic rde_q;
   logic pending_q;
   logic wr_p1;
   logic wr_opt;
   logic [CULL_W-1:0] cull_cnt_q;
   logic [CULL_W-1:0] cull_base;
   logic [CULL_W-1:0] cull_n;
   logic crest_en;
   logic valley_en;
   logic crest_ev;
   logic valley_ev;
   logic timing;
   logic issue;
   logic point;
   logic xfer;
   logic crest_irq_q;
   logic valley_irq_q;
   logic dir_q;
   logic slope_new;
   logic [NPH-1:0] done_q;
   logic [NPH-1:0] dmatch;

   // One wait state: read data is captured while waitrequest is high
   assign waitrequest = (read | write) & ~ack_q;
   assign wr_acc = write & ack_q;
   assign sh_hit = address < OFF_OPTA;
   assign wr_idx = address[IDX_MSB:IDX_LSB];
   assign wmerge = {byteenable[1] ? writedata[15:8] : reg_q[wr_idx][15:8],
                    byteenable[0] ? writedata[7:0] : reg_q[wr_idx][7:0]};
   assign wr_p1 = wr_acc & (address == OFF_DUTY1);
   assign wr_opt = wr_acc & (address == OFF_OPT1);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         ack_q <= 1'b0;
      else
         ack_q <= (read | write) & ~ack_q;
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (sh_hit)
         rdata_d[DW-1:0] = reg_q[wr_idx];
      else if (address == OFF_OPTA)
      begin
         rdata_d[ANYTIME_BIT] = anytime_q;
         rdata_d[DOWN_BIT] = count_down;
         rdata_d[PEND_BIT] = pending_q;
      end
      else if (address == OFF_OPTC)
         rdata_d[RDE_BIT] = rde_q;
      else if (address == OFF_STAT)
         rdata_d[CULL_W-1:0] = cull_cnt_q;
   end

   // Unmapped reads return zero, unmapped writes are dropped
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_q <= 32'h0000_0000;
      else if (read & ~ack_q)
         rdata_q <= rdata_d;
   end
   assign readdata = rdata_q;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         anytime_q <= 1'b0;
         rde_q <= 1'b0;
      end
      else if (wr_acc & byteenable[0])
      begin
         if (address == OFF_OPTA)
            anytime_q <= writedata[ANYTIME_BIT];
         if (address == OFF_OPTC)
            rde_q <= writedata[RDE_BIT];
      end
   end

   // Buffered register file; buffers feed the compare logic
   generate
      for (genvar i = 0; i < NREG; i++)
      begin : g_reg
         logic hit;
         logic [DW-1:0] wv;
         assign hit = wr_acc & sh_hit & (wr_idx == 3'(i));
         assign wv = (3'(i) == IDX_OPT1) ? (wmerge & OPT1_MASK) : wmerge;
         always_ff @(posedge clock or posedge sys_rst)
         begin
            if (sys_rst)
               reg_q[i] <= RST_VAL;
            else if (hit)
               reg_q[i] <= wv;
         end
         always_ff @(posedge clock or posedge sys_rst)
         begin
            if (sys_rst)
               buf_q[i] <= RST_VAL;
            else if (anytime_q & hit)
               buf_q[i] <= wv;
            else if (xfer)
               buf_q[i] <= reg_q[i];
         end
      end
   endgenerate

   assign cycle_buf = buf_q[IDX_CYCLE];
   assign duty1_buf = buf_q[IDX_DUTY1];
   assign duty2_buf = buf_q[IDX_DUTY2];
   assign duty3_buf = buf_q[IDX_DUTY3];
   assign conv_a_buf = buf_q[IDX_CONVA];
   assign conv_b_buf = buf_q[IDX_CONVB];

   assign cull_n = buf_q[IDX_OPT1][CULL_LSB +: CULL_W];
   assign crest_en = buf_q[IDX_OPT1][CREST_EN_BIT];
   assign valley_en = buf_q[IDX_OPT1][VALLEY_EN_BIT];

   // Carrier positions; only these two take part in culling
   assign crest_ev = ~count_down & (cnt_val == cycle_buf);
   assign valley_ev = count_down & (cnt_val == VALLEY_CNT);
   assign timing = (crest_ev & crest_en) | (valley_ev & valley_en);

   // A write to the option register discards the count but not this timing
   assign cull_base = wr_opt ? '0 : cull_cnt_q;
   assign issue = timing & (cull_base == cull_n);

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         cull_cnt_q <= '0;
      else if (issue)
         cull_cnt_q <= '0;
      else if (timing)
         cull_cnt_q <= cull_base + CNT_ONE;
      else
         cull_cnt_q <= cull_base;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         crest_irq_q <= 1'b0;
         valley_irq_q <= 1'b0;
      end
      else
      begin
         crest_irq_q <= issue & crest_ev & crest_en;
         valley_irq_q <= issue & valley_ev & valley_en;
      end
   end
   assign crest_irq = crest_irq_q;
   assign valley_irq = valley_irq_q;

   // Transfer point depends on the batch flavour; anytime never arms
   assign point = rde_q ? issue : (crest_ev | valley_ev);
   assign xfer = pending_q & point & ~anytime_q;

   // A fresh phase-one write in the transfer cycle keeps the arm set
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         pending_q <= 1'b0;
      else
         pending_q <= (wr_p1 & ~anytime_q) | (pending_q & ~xfer);
   end

   // Duty compares, once per slope
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         dir_q <= 1'b0;
      else
         dir_q <= count_down;
   end
   assign slope_new = count_down != dir_q;

   generate
      for (genvar p = 0; p < NPH; p++)
      begin : g_duty
         // Compared against the live buffer, so an early rewrite counts
         assign dmatch[p] = (cnt_val == buf_q[p + 1]) & (slope_new | ~done_q[p]);
         always_ff @(posedge clock or posedge sys_rst)
         begin
            if (sys_rst)
               done_q[p] <= 1'b0;
            else if (dmatch[p])
               done_q[p] <= 1'b1;
            else if (slope_new)
               done_q[p] <= 1'b0;
         end
      end
   endgenerate

   assign duty_match = dmatch;
   assign cycle_match = crest_ev;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_crest_gate;
      crest_irq_q |-> $past(crest_ev) && $past(crest_en);
   endproperty
   a_crest_gate: assert property (p_crest_gate) else $error("crest irq without enable");

   property p_valley_gate;
      valley_irq_q |-> $past(valley_ev) && $past(valley_en);
   endproperty
   a_valley_gate: assert property (p_valley_gate) else $error("valley irq without enable");

   property p_cull_hit;
      (crest_irq_q || valley_irq_q) |-> $past(cull_base == cull_n);
   endproperty
   a_cull_hit: assert property (p_cull_hit) else $error("irq before cull count reached");

   property p_no_cull;
      (timing && cull_n == '0) |=> (crest_irq_q || valley_irq_q);
   endproperty
   a_no_cull: assert property (p_no_cull) else $error("zero cull count dropped irq");

   property p_rde_xfer;
      (xfer && rde_q) |-> issue;
   endproperty
   a_rde_xfer: assert property (p_rde_xfer) else $error("culled transfer off irq");

   property p_batch_load;
      (pending_q && (crest_ev || valley_ev) && !rde_q && !anytime_q)
         |=> buf_q[IDX_DUTY1] == $past(reg_q[IDX_DUTY1]) && ($past(wr_p1) || !pending_q);
   endproperty
   a_batch_load: assert property (p_batch_load) else $error("batch transfer missed");

   property p_anytime;
      (wr_acc && anytime_q && address == OFF_DUTY2) |=> buf_q[IDX_DUTY2] == reg_q[IDX_DUTY2];
   endproperty
   a_anytime: assert property (p_anytime) else $error("anytime write not applied");

   property p_anytime_no_arm;
      (wr_p1 && anytime_q && !pending_q) |=> !pending_q;
   endproperty
   a_anytime_no_arm: assert property (p_anytime_no_arm) else $error("anytime write armed transfer");

   property p_arm;
      (wr_p1 && !anytime_q) |=> pending_q;
   endproperty
   a_arm: assert property (p_arm) else $error("phase-one write did not arm");

   property p_other_no_arm;
      (wr_acc && address != OFF_DUTY1 && !pending_q) |=> !pending_q;
   endproperty
   a_other_no_arm: assert property (p_other_no_arm) else $error("other register write armed transfer");

   property p_batch_point;
      (pending_q && !rde_q && !anytime_q && (crest_ev || valley_ev)) |-> xfer;
   endproperty
   a_batch_point: assert property (p_batch_point) else $error("batch transfer point skipped");

   property p_culled_point;
      (rde_q && !issue) |-> !xfer;
   endproperty
   a_culled_point: assert property (p_culled_point) else $error("transfer at culled timing");

   property p_one_kind;
      !(crest_irq_q && valley_irq_q);
   endproperty
   a_one_kind: assert property (p_one_kind) else $error("crest and valley irq together");

   property p_hold;
      (!pending_q && !wr_acc) |=> $stable(buf_q[IDX_CONVA]) && $stable(buf_q[IDX_CYCLE]);
   endproperty
   a_hold: assert property (p_hold) else $error("buffer moved without transfer");

   property p_cycle_up;
      cycle_match |-> !count_down;
   endproperty
   a_cycle_up: assert property (p_cycle_up) else $error("cycle match while down");

   property p_duty_once;
      duty_match[0] |=> !duty_match[0] || (count_down != $past(count_down));
   endproperty
   a_duty_once: assert property (p_duty_once) else $error("second duty match in slope");

   property p_opt_clear;
      (wr_opt && !timing) |=> cull_cnt_q == '0;
   endproperty
   a_opt_clear: assert property (p_opt_clear) else $error("cull counter not cleared");

   property p_restart;
      issue |=> cull_cnt_q == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("cull counter not restarted");

   property p_cull_step;
      (timing && !issue) |=> cull_cnt_q == $past(cull_base) + CNT_ONE;
   endproperty
   a_cull_step: assert property (p_cull_step) else $error("cull counter did not advance");

   c_alternate: cover property (crest_irq_q ##[1:1000] valley_irq_q);
   c_cull_xfer: cover property (xfer && rde_q && cull_n != '0);
   c_anytime: cover property (wr_acc && anytime_q && address == OFF_CYCLE);
   c_batch_xfer: cover property (xfer && !rde_q);
   c_duty_rematch: cover property (duty_match[0] && slope_new);
endmodule
`default_nettype wire

// *** verilog/pwm_cull_pkg.sv ***
// Constants for crest/valley interrupt culling and buffered reload.
// Assumes a 16-bit up/down counter core outside this block.
package pwm_cull_pkg;
   localparam int DW = 16;
   localparam int AW = 6;
   localparam int NREG = 7;
   localparam int NPH = 3;
   localparam int CULL_W = 5;
   // Byte offsets of the Avalon registers
   localparam logic [AW-1:0] OFF_CYCLE = 6'h00;
   localparam logic [AW-1:0] OFF_DUTY1 = 6'h04;
   localparam logic [AW-1:0] OFF_DUTY2 = 6'h08;
   localparam logic [AW-1:0] OFF_DUTY3 = 6'h0C;
   localparam logic [AW-1:0] OFF_OPT1 = 6'h10;
   localparam logic [AW-1:0] OFF_CONVA = 6'h14;
   localparam logic [AW-1:0] OFF_CONVB = 6'h18;
   localparam logic [AW-1:0] OFF_OPTA = 6'h1C;
   localparam logic [AW-1:0] OFF_OPTC = 6'h20;
   localparam logic [AW-1:0] OFF_STAT = 6'h24;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 4;
   // Index of each buffered register
   localparam logic [2:0] IDX_CYCLE = 3'h0;
   localparam logic [2:0] IDX_DUTY1 = 3'h1;
   localparam logic [2:0] IDX_DUTY2 = 3'h2;
   localparam logic [2:0] IDX_DUTY3 = 3'h3;
   localparam logic [2:0] IDX_OPT1 = 3'h4;
   localparam logic [2:0] IDX_CONVA = 3'h5;
   localparam logic [2:0] IDX_CONVB = 3'h6;
   // Culling option register fields
   localparam int CULL_LSB = 0;
   localparam int VALLEY_EN_BIT = 6;
   localparam int CREST_EN_BIT = 7;
   localparam logic [DW-1:0] OPT1_MASK = 16'h00DF;
   // Option register a / c fields
   localparam int ANYTIME_BIT = 0;
   localparam int DOWN_BIT = 1;
   localparam int PEND_BIT = 2;
   localparam int RDE_BIT = 0;
   localparam logic [DW-1:0] RST_VAL = 16'h0000;
   localparam logic [DW-1:0] VALLEY_CNT = 16'h0001;
   localparam logic [CULL_W-1:0] CNT_ONE = 5'h01;
endpackage

// *** dv/tb_pwm_irq_cull.sv ***
// Self-checking bench for crest/valley interrupt culling and buffered reload.
// Assumes the block alone: the bench plays the counter core and the Avalon master.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_irq_cull;
   import pwm_cull_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [AW-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = '0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [DW-1:0] cnt_val = 16'h8000;
   logic count_down = 1'b0;
   logic crest_irq;
   logic valley_irq;
   logic cycle_match;
   logic [NPH-1:0] duty_match;
   logic [DW-1:0] cycle_buf, duty1_buf, duty2_buf, duty3_buf, conv_a_buf, conv_b_buf;
   logic [31:0] rdata;
   int mismatches = 0;
   int n_tests = 0;

   always #20 clock = ~clock;

   pwm_irq_cull i_pwm_irq_cull (.clock(clock), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .cnt_val(cnt_val), .count_down(count_down), .crest_irq(crest_irq),
      .valley_irq(valley_irq), .cycle_match(cycle_match), .duty_match(duty_match),
      .cycle_buf(cycle_buf), .duty1_buf(duty1_buf), .duty2_buf(duty2_buf), .duty3_buf(duty3_buf),
      .conv_a_buf(conv_a_buf), .conv_b_buf(conv_b_buf));

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic rd, input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= rd;
      write <= ~rd;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0)
      begin
         mismatches++;
         conclude();
      end
      @(posedge clock);
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask

   task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
      bus(1'b1, a, 32'h0000_0000);
      check(rdata, exp);
   endtask

   // One-cycle counter event, then idle value that matches nothing
   task automatic ev(input logic [DW-1:0] c, input logic d, input logic ec, input logic ev_v);
      cnt_val <= c;
      count_down <= d;
      @(posedge clock);
      cnt_val <= 16'h8000;
      count_down <= 1'b0;
      // Pulse launched at the event edge still stands here
      @(posedge clock);
      check(crest_irq, ec);
      check(valley_irq, ev_v);
   endtask

   // Counter value held one cycle; compare outputs taken at its closing edge
   task automatic cmp(input logic [DW-1:0] c, input logic d, input logic em, input logic [NPH-1:0] edm);
      cnt_val <= c;
      count_down <= d;
      @(posedge clock);
      check(cycle_match, em);
      check(duty_match, edm);
   endtask

   initial
   begin
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      check(cycle_buf, 16'h0000);
      rdchk(OFF_OPTA, 32'h0000_0000);
      wr(6'h28, 32'h0000_FFFF);
      rdchk(6'h28, 32'h0000_0000);
      // Anytime mode, transfer culling set but ignored
      wr(OFF_OPTA, 32'h0000_0001);
      wr(OFF_OPTC, 32'h0000_0001);
      wr(OFF_CYCLE, 32'h0000_0040);
      check(cycle_buf, 16'h0040);
      wr(OFF_DUTY2, 32'h0000_0011);
      check(duty2_buf, 16'h0011);
      wr(OFF_OPT1, 32'h0000_00C0);
      rdchk(OFF_OPT1, 32'h0000_00C0);
      ev(16'h0040, 1'b0, 1'b1, 1'b0);
      ev(16'h0001, 1'b1, 1'b0, 1'b1);
      ev(16'h0040, 1'b1, 1'b0, 1'b0);
      wr(OFF_OPT1, 32'h0000_00C1);
      ev(16'h0040, 1'b0, 1'b0, 1'b0);
      rdchk(OFF_STAT, 32'h0000_0001);
      wr(OFF_OPT1, 32'h0000_00C1);
      rdchk(OFF_STAT, 32'h0000_0000);
      ev(16'h0040, 1'b0, 1'b0, 1'b0);
      ev(16'h0001, 1'b1, 1'b0, 1'b1);
      wr(OFF_OPT1, 32'h0000_00C4);
      for (int i = 0; i < 5; i++)
         ev(i[0] ? 16'h0001 : 16'h0040, i[0], i == 4, 1'b0);
      wr(OFF_OPT1, 32'h0000_0080);
      ev(16'h0001, 1'b1, 1'b0, 1'b0);
      ev(16'h0040, 1'b0, 1'b1, 1'b0);
      wr(OFF_OPT1, 32'h0000_0040);
      ev(16'h0040, 1'b0, 1'b0, 1'b0);
      ev(16'h0001, 1'b1, 1'b0, 1'b1);
      // Batch mode: only a phase-one write arms the copy
      wr(OFF_OPTA, 32'h0000_0000);
      wr(OFF_OPTC, 32'h0000_0000);
      wr(OFF_OPT1, 32'h0000_00C1);
      wr(OFF_CYCLE, 32'h0000_0050);
      wr(OFF_DUTY3, 32'h0000_0033);
      wr(OFF_CONVB, 32'h0000_00BB);
      check(duty3_buf, 16'h0000);
      ev(16'h0040, 1'b0, 1'b0, 1'b0);
      check(cycle_buf, 16'h0040);
      wr(OFF_CONVA, 32'h0000_00AA);
      wr(OFF_DUTY1, 32'h0000_0022);
      rdchk(OFF_OPTA, 32'h0000_0004);
      ev(16'h0001, 1'b1, 1'b0, 1'b1);
      check(cycle_buf, 16'h0050);
      check(duty1_buf, 16'h0022);
      check(duty3_buf, 16'h0033);
      check(conv_a_buf, 16'h00AA);
      check(conv_b_buf, 16'h00BB);
      // Intermittent batch: copy waits for the issued culled interrupt
      wr(OFF_OPTC, 32'h0000_0001);
      wr(OFF_OPT1, 32'h0000_00C1);
      wr(OFF_DUTY2, 32'h0000_0044);
      wr(OFF_DUTY1, 32'h0000_0055);
      ev(16'h0050, 1'b0, 1'b0, 1'b0);
      check(duty1_buf, 16'h0022);
      ev(16'h0001, 1'b1, 1'b0, 1'b1);
      check(duty1_buf, 16'h0055);
      check(duty2_buf, 16'h0044);
      // Anytime compares: one match per slope, early rewrite used at once
      wr(OFF_OPTA, 32'h0000_0001);
      wr(OFF_DUTY2, 32'h0000_0070);
      cmp(16'h0044, 1'b0, 1'b0, 3'b000);
      cmp(16'h0055, 1'b0, 1'b0, 3'b001);
      cmp(16'h0070, 1'b0, 1'b0, 3'b010);
      wr(OFF_DUTY1, 32'h0000_0060);
      cmp(16'h0060, 1'b0, 1'b0, 3'b000);
      cmp(16'h0060, 1'b1, 1'b0, 3'b001);
      cmp(16'h0050, 1'b1, 1'b0, 3'b000);
      cmp(16'h0050, 1'b0, 1'b1, 3'b000);
      wr(OFF_CYCLE, 32'h0000_0020);
      cmp(16'h0051, 1'b0, 1'b0, 3'b000);
      cmp(16'h0020, 1'b0, 1'b1, 3'b000);
      conclude();
   end
endmodule
`default_nettype wire
